// ---- channel_result_math_engine.sv ----
// Purpose: averaging, scaling and function engine of a four-channel input module
// Assumes: samples arrive on clk from the front end, registers over APB
// Notes: values are 32-bit signed integers, products keep the low 32 bits
`timescale 1ns/1ps
`default_nettype none
module channel_result_math_engine
	import math_engine_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
)(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire sample_s [3:0] samp,
	output link_cfg_s cfg232,
	output link_cfg_s cfg485
);
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001, ST_DIVW = 9'h002, ST_LIN = 9'h004, ST_LINE = 9'h008,
		ST_STORE = 9'h010, ST_FN1 = 9'h020, ST_FN2 = 9'h040, ST_SQRT = 9'h080,
		ST_FEND = 9'h100
	} st_e;

	typedef struct packed {
		st_e st;
		st_e ret;
		logic [3:0] en;
		logic [3:0] lin;
		logic [3:0] pend;
		logic [3:0] ovr;
		logic [3:0] ovr_s;
		logic [3:0] mxh;
		logic [3:0] mnh;
		logic [11:0] fsel;
		op_e op1;
		op_e op2;
		logic [1:0] fop;
		link_cfg_s l232;
		link_cfg_s l485;
		logic [3:0][15:0] per;
		logic [3:0][15:0] tk;
		logic [3:0][31:0] x1;
		logic [3:0][31:0] y1;
		logic [3:0][31:0] x2;
		logic [3:0][31:0] y2;
		logic [3:0][31:0] lead;
		logic [3:0][31:0] res;
		logic [3:0][31:0] mx;
		logic [3:0][31:0] mn;
		logic [3:0][31:0] acc;
		logic [3:0][31:0] snap;
		logic [3:0][31:0] cnt;
		logic [3:0][31:0] cnt_s;
		logic [31:0] tick;
		logic [1:0] ch;
		logic hi;
		logic sqon;
		logic neg;
		logic dz;
		logic dstart;
		logic [31:0] dnd;
		logic [31:0] dsr;
		logic [31:0] t;
		logic [31:0] val;
		logic [31:0] sx;
		logic [31:0] sr;
		logic [31:0] sb;
		logic [31:0] fres;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} main_s;

	main_s r;
	main_s n;
	logic div_done;
	logic [31:0] div_quot;
	logic setup, wr, hit, chsel, tick_now, allz;
	logic [2:0] c3;
	logic [1:0] ci;
	logic [5:0] off;
	logic [31:0] rdata, oa, ob, oc, fl, fr, v, prod;
	op_e fo;

	// Add, subtract or multiply; divide goes through the divider
	function automatic logic [31:0] alu(input logic [31:0] a, input logic [31:0] b,
		input op_e op);
		case (op)
			OP_ADD: alu = a + b;
			OP_SUB: alu = a - b;
			default: alu = a * b;
		endcase
	endfunction

	// Operand selector: channel result or its square
	function automatic logic [31:0] opnd(input logic [3:0] sel,
		input logic [3:0][31:0] res);
		logic [1:0] k;
		k = sel[1:0] - 2'd1;
		if (sel >= SEL_RES_LO && sel <= SEL_RES_HI) begin
			opnd = res[k];
		end else if (sel >= SEL_SQ_LO && sel <= SEL_SQ_HI) begin
			opnd = res[k] * res[k];
		end else begin
			opnd = '0;
		end
	endfunction

	// Signed division launched as magnitudes, sign restored on return
	function automatic main_s launch(input main_s s, input logic [31:0] a,
		input logic [31:0] b, input st_e ret);
		main_s o;
		o = s;
		o.neg = a[31] ^ b[31];
		o.dz = (b == '0);
		o.dnd = a[31] ? -a : a;
		o.dsr = b[31] ? -b : b;
		o.dstart = 1'b1;
		o.ret = ret;
		o.st = ST_DIVW;
		return o;
	endfunction

	div_unit u_div (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.start(r.dstart),
		.dividend(r.dnd),
		.divisor(r.dsr),
		.done(div_done),
		.quot(div_quot)
	);

	// Next state: bus decode, processing sequence, averaging timers
	always_comb begin
		n = r;
		n.dstart = 1'b0;
		setup = psel && !penable;
		wr = psel && penable && r.pready && pwrite;
		c3 = paddr[8:6] - 3'd1;
		ci = c3[1:0];
		off = paddr[5:0];
		chsel = (paddr[11:9] == 3'h0) && (paddr[8:6] != 3'h0) && (paddr[8:6] <= 3'h4);
		hit = 1'b1;
		rdata = '0;
		// Address decode and register writes
		if (paddr[1:0] != 2'h0) begin
			hit = 1'b0;
		end else if (paddr == A_CTRL) begin
			rdata = {23'h0, 1'b0, r.lin, r.en};
			if (wr) begin
				n.en = pwdata[CTRL_EN +: 4];
				n.lin = pwdata[CTRL_LIN +: 4];
				if (pwdata[CTRL_CLR]) begin
					n.mx = {NCH{NEG_MAX}};
					n.mn = {NCH{MARK}};
					n.mxh = '0;
					n.mnh = '0;
				end
			end
		end else if (paddr == A_FUNC) begin
			rdata = {14'h0, r.fop, r.op2, r.op1, r.fsel};
			if (wr) begin
				n.fsel = pwdata[F_SEL +: 12];
				n.op1 = op_e'(pwdata[F_OP1 +: 2]);
				n.op2 = op_e'(pwdata[F_OP2 +: 2]);
				n.fop = pwdata[F_FOP +: 2];
			end
		end else if (paddr == A_STAT) begin
			rdata = {27'h0, r.st != ST_IDLE, r.pend};
		end else if (paddr == A_FRES) begin
			rdata = r.fres;
		end else if (paddr == A_LINK) begin
			rdata = {19'h0, r.l485};
			if (wr) begin
				n.l485 = link_cfg_s'(pwdata[12:0]);
			end
		end else if (chsel && off == O_PER) begin
			rdata = {16'h0, r.per[ci]};
			if (wr) begin
				n.per[ci] = pwdata[15:0];
			end
		end else if (chsel && off == O_X1) begin
			rdata = r.x1[ci];
			if (wr) begin
				n.x1[ci] = pwdata;
			end
		end else if (chsel && off == O_Y1) begin
			rdata = r.y1[ci];
			if (wr) begin
				n.y1[ci] = pwdata;
			end
		end else if (chsel && off == O_X2) begin
			rdata = r.x2[ci];
			if (wr) begin
				n.x2[ci] = pwdata;
			end
		end else if (chsel && off == O_Y2) begin
			rdata = r.y2[ci];
			if (wr) begin
				n.y2[ci] = pwdata;
			end
		end else if (chsel && off == O_LEAD) begin
			rdata = r.lead[ci];
			if (wr) begin
				n.lead[ci] = pwdata;
			end
		end else if (chsel && off == O_RES) begin
			rdata = r.res[ci];
		end else if (chsel && off == O_MAX) begin
			rdata = r.mx[ci];
		end else if (chsel && off == O_MIN) begin
			rdata = r.mn[ci];
		end else begin
			hit = 1'b0;
		end
		// Answer in the first access cycle
		n.pready = setup;
		n.pslverr = setup && !hit;
		n.prdata = (setup && hit && !pwrite) ? rdata : '0;

		// Processing sequence for one channel, then the function
		oa = opnd(r.fsel[3:0], r.res);
		ob = opnd(r.fsel[7:4], r.res);
		oc = opnd(r.fsel[11:8], r.res);
		fl = '0;
		fr = '0;
		fo = OP_ADD;
		v = r.t - r.lead[r.ch];
		prod = (v - r.x1[r.ch]) * (r.y2[r.ch] - r.y1[r.ch]);
		allz = ~|{r.x1[r.ch], r.y1[r.ch], r.x2[r.ch], r.y2[r.ch]};
		case (r.st)
			ST_IDLE: begin
				for (int i = NCH - 1; i >= 0; i--) begin
					if (r.pend[i]) begin
						n.ch = 2'(i);
					end
				end
				if (|r.pend) begin
					n.pend[n.ch] = 1'b0;
					n = launch(n, r.snap[n.ch], r.cnt_s[n.ch], ST_LIN);
				end
			end
			ST_DIVW: begin
				if (div_done) begin
					n.t = r.dz ? MARK : (r.neg ? -div_quot : div_quot);
					n.st = r.ret;
				end
			end
			ST_LIN: begin
				n.st = ST_STORE;
				if (r.ovr_s[r.ch] || r.t == MARK) begin
					n.val = MARK;
				end else if (!r.lin[r.ch]) begin
					n.val = v;
				end else if (allz) begin
					n.val = '0;
				end else begin
					n = launch(n, prod, r.x2[r.ch] - r.x1[r.ch], ST_LINE);
				end
			end
			ST_LINE: begin
				n.val = (r.t == MARK) ? MARK : r.t + r.y1[r.ch];
				n.st = ST_STORE;
			end
			ST_STORE: begin
				if (r.en[r.ch]) begin
					n.res[r.ch] = r.val;
					if (r.val == MARK || n.mxh[r.ch]) begin
						n.mx[r.ch] = MARK;
						n.mxh[r.ch] = 1'b1;
					end else if ($signed(r.val) > $signed(n.mx[r.ch])) begin
						n.mx[r.ch] = r.val;
					end
					if (r.val == MARK || n.mnh[r.ch]) begin
						n.mn[r.ch] = MARK;
						n.mnh[r.ch] = 1'b1;
					end else if ($signed(r.val) < $signed(n.mn[r.ch])) begin
						n.mn[r.ch] = r.val;
					end
				end
				n.st = ST_FN1;
			end
			ST_FN1: begin
				n.hi = r.op2[1] && !r.op1[1];
				fl = n.hi ? ob : oa;
				fr = n.hi ? oc : ob;
				fo = n.hi ? r.op2 : r.op1;
				n.t = alu(fl, fr, fo);
				n.st = ST_FN2;
				if (fo == OP_DIV) begin
					n = launch(n, fl, fr, ST_FN2);
				end
			end
			ST_FN2: begin
				fl = r.hi ? oa : r.t;
				fr = r.hi ? r.t : oc;
				fo = r.hi ? r.op1 : r.op2;
				n.t = alu(fl, fr, fo);
				n.st = ST_SQRT;
				if (fo == OP_DIV) begin
					n = launch(n, fl, fr, ST_SQRT);
				end
			end
			ST_SQRT: begin
				if (!r.sqon) begin
					if (r.fop != FOP_SQRT) begin
						n.fres = r.t;
						n.st = ST_FEND;
					end else if (r.t[31] || r.t == MARK) begin
						n.fres = MARK;
						n.st = ST_FEND;
					end else begin
						n.sx = r.t;
						n.sr = '0;
						n.sb = SQ_BIT0;
						n.sqon = 1'b1;
					end
				end else begin
					if (r.sx >= r.sr + r.sb) begin
						n.sx = r.sx - (r.sr + r.sb);
						n.sr = (r.sr >> 1) + r.sb;
					end else begin
						n.sr = r.sr >> 1;
					end
					n.sb = r.sb >> 2;
					if (r.sb == 32'h1) begin
						n.fres = n.sr;
						n.sqon = 1'b0;
						n.st = ST_FEND;
					end
				end
			end
			ST_FEND: begin
				n.st = ST_IDLE;
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase

		// Averaging timers and sample accumulation per channel
		tick_now = (r.tick == 32'(TICK_CYCLES - 1));
		n.tick = tick_now ? '0 : r.tick + 32'h1;
		for (int i = 0; i < NCH; i++) begin
			if (tick_now) begin
				if (r.per[i] == '0 || r.tk[i] + 16'h1 >= r.per[i]) begin
					n.tk[i] = '0;
				end else begin
					n.tk[i] = r.tk[i] + 16'h1;
				end
				if (r.per[i] != '0 && r.tk[i] + 16'h1 >= r.per[i]) begin
					n.snap[i] = r.acc[i];
					n.cnt_s[i] = r.cnt[i];
					n.ovr_s[i] = r.ovr[i];
					n.acc[i] = '0;
					n.cnt[i] = '0;
					n.ovr[i] = 1'b0;
					n.pend[i] = 1'b1;
				end
			end
			if (r.en[i] && samp[i].valid) begin
				n.acc[i] = n.acc[i] + samp[i].data;
				n.cnt[i] = n.cnt[i] + 32'h1;
				n.ovr[i] = n.ovr[i] | samp[i].ovr;
			end
			if (!n.en[i]) begin
				n.acc[i] = '0;
				n.cnt[i] = '0;
				n.ovr[i] = 1'b0;
				n.tk[i] = '0;
				n.pend[i] = 1'b0;
				n.res[i] = '0;
			end
		end
		n.l232 = CFG232;
	end

	// State register; reset values per field
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.ret <= ST_IDLE;
			r.l232 <= CFG232;
			r.l485 <= CFG485_RST;
			r.per <= {NCH{PER_RST}};
			r.mx <= {NCH{NEG_MAX}};
			r.mn <= {NCH{MARK}};
		end else if (ce) begin
			r <= n;
		end
	end

	// Outputs straight from the state register
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign cfg232 = r.l232;
	assign cfg485 = r.l485;

	// Checks on the processing sequence, averaging timers and serial port settings
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst || !ce);
	sequence s_store;
		r.st == ST_STORE;
	endsequence
	sequence s_func_done;
		r.st == ST_FEND;
	endsequence

	a_rs232_fixed: assert property (cfg232 == CFG232 && $stable(cfg232))
		else $error("serial port settings changed");
	a_dis_zero: assert property (!r.en[0] |-> r.res[0] == '0)
		else $error("disabled channel result not zero");
	a_zero_char: assert property ((r.st == ST_LIN && r.lin[r.ch] && allz && !r.ovr_s[r.ch]
		&& r.t != MARK) |=> r.val == '0 && r.st == ST_STORE)
		else $error("zero characteristic gave nonzero");
	a_prec_mul: assert property ((r.st == ST_FN1 && r.op1 == OP_ADD && r.op2 == OP_MUL)
		|-> fo == OP_MUL && fl == ob && fr == oc)
		else $error("multiply not evaluated first");
	a_left_first: assert property ((r.st == ST_FN1 && r.op1 == OP_DIV && r.op2 == OP_DIV)
		|-> fl == oa && fr == ob)
		else $error("leftmost division not first");
	a_ovr_mark: assert property ((r.st == ST_LIN && r.ovr_s[r.ch])
		|=> r.val == MARK && r.st == ST_STORE)
		else $error("overrange marker not loaded");
	a_max_hold: assert property ((r.mxh[2] && !(wr && paddr == A_CTRL && pwdata[CTRL_CLR]))
		|=> r.mx[2] == MARK)
		else $error("held maximum marker lost");
	a_lead_comp: assert property ((r.st == ST_LIN && !r.lin[r.ch] && !r.ovr_s[r.ch]
		&& r.t != MARK) |=> r.val == $past(r.t) - $past(r.lead[r.ch]))
		else $error("lead resistance not subtracted");
	a_period_pend: assert property ((tick_now && r.en[0] && r.per[0] != '0 && !wr
		&& r.tk[0] + 16'h1 >= r.per[0]) |=> r.pend[0] && r.tk[0] == '0)
		else $error("period end not flagged");
	a_mul_code: assert property ((r.st == ST_FN1 && fo == OP_MUL)
		|=> r.t == 32'($past(fl) * $past(fr)) && r.st == ST_FN2)
		else $error("multiply result wrong");
	a_sel_square: assert property ((r.fsel[3:0] == 4'ha) |-> oa == 32'(r.res[1] * r.res[1]))
		else $error("squared operand wrong");
	a_sel_direct: assert property ((r.fsel[11:8] == 4'h3) |-> oc == r.res[2])
		else $error("direct operand wrong");
	a_func_follow: assert property (s_store |-> ##[1:200] s_func_done)
		else $error("function not recomputed");
endmodule
`default_nettype wire

// ---- math_engine_pkg.sv ----
// Purpose: shared constants and carrier types of the channel result engine
// Assumes: 40 MHz clock, APB register access, 32-bit signed integer values
// Notes: register map is word aligned, channel blocks repeat every 0x40
`default_nettype none
package math_engine_pkg;
	localparam int NCH = 4;
	// Timing: averaging period unit is 100 ms
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_MS = 100;
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam logic [15:0] PER_RST = 16'h000a;
	// Marker loaded for an out-of-range measurement
	localparam logic [31:0] MARK = 32'h7fff_ffff;
	localparam logic [31:0] NEG_MAX = 32'h8000_0000;
	localparam logic [31:0] SQ_BIT0 = 32'h4000_0000;
	// Register byte offsets
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_FUNC = 12'h004;
	localparam logic [11:0] A_STAT = 12'h008;
	localparam logic [11:0] A_FRES = 12'h00c;
	localparam logic [11:0] A_LINK = 12'h010;
	// Offsets inside a channel block, block n at 0x40 * (n + 1)
	localparam logic [5:0] O_PER = 6'h00;
	localparam logic [5:0] O_X1 = 6'h04;
	localparam logic [5:0] O_Y1 = 6'h08;
	localparam logic [5:0] O_X2 = 6'h0c;
	localparam logic [5:0] O_Y2 = 6'h10;
	localparam logic [5:0] O_LEAD = 6'h14;
	localparam logic [5:0] O_RES = 6'h18;
	localparam logic [5:0] O_MAX = 6'h1c;
	localparam logic [5:0] O_MIN = 6'h20;
	// Field positions
	localparam int CTRL_EN = 0;
	localparam int CTRL_LIN = 4;
	localparam int CTRL_CLR = 8;
	localparam int F_SEL = 0;
	localparam int F_OP1 = 12;
	localparam int F_OP2 = 14;
	localparam int F_FOP = 16;
	// Operators and operand selectors
	typedef enum logic [1:0] {OP_ADD = 2'h0, OP_SUB = 2'h1, OP_MUL = 2'h2, OP_DIV = 2'h3} op_e;
	localparam logic [1:0] FOP_SQRT = 2'h1;
	localparam logic [3:0] SEL_RES_LO = 4'h1;
	localparam logic [3:0] SEL_RES_HI = 4'h4;
	localparam logic [3:0] SEL_SQ_LO = 4'h9;
	localparam logic [3:0] SEL_SQ_HI = 4'hc;
	// Serial port settings
	typedef struct packed {
		logic [2:0] baud;
		logic [1:0] mode;
		logic [7:0] addr;
	} link_cfg_s;
	localparam link_cfg_s CFG232 = '{baud: 3'h2, mode: 2'h0, addr: 8'h01};
	localparam link_cfg_s CFG485_RST = '{baud: 3'h2, mode: 2'h0, addr: 8'h01};
	// One sample from the front end
	typedef struct packed {
		logic valid;
		logic ovr;
		logic [31:0] data;
	} sample_s;
	// Divider state
	typedef struct packed {
		logic busy;
		logic done;
		logic [5:0] n;
		logic [31:0] q;
		logic [31:0] rm;
		logic [31:0] d;
	} div_s;
endpackage
`default_nettype wire

// ---- div_unit.sv ----
// Purpose: unsigned 32-bit restoring divider, one quotient bit per cycle
// Assumes: start is ignored while busy; divisor zero gives all ones
// Notes: done pulses one cycle, 33 enabled cycles after start
`timescale 1ns/1ps
`default_nettype none
module div_unit
	import math_engine_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic start,
	input wire logic [31:0] dividend,
	input wire logic [31:0] divisor,
	output logic done,
	output logic [31:0] quot
);
	div_s r;
	div_s n;
	logic [32:0] trial;

	// Shift and subtract step
	always_comb begin
		n = r;
		n.done = 1'b0;
		trial = {r.rm, r.q[31]} - {1'b0, r.d};
		if (start && !r.busy) begin
			n.busy = 1'b1;
			n.n = 6'd32;
			n.q = dividend;
			n.rm = '0;
			n.d = divisor;
		end else if (r.busy) begin
			n.q = {r.q[30:0], !trial[32]};
			n.rm = trial[32] ? {r.rm[30:0], r.q[31]} : trial[31:0];
			n.n = r.n - 6'd1;
			if (r.n == 6'd1) begin
				n.busy = 1'b0;
				n.done = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
		end else if (ce) begin
			r <= n;
		end
	end

	assign done = r.done;
	assign quot = r.q;
endmodule
`default_nettype wire

// ---- front_end_model.sv ----
// Purpose: front-end model, one sample per channel every GAP cycles
// Assumes: same clock as the engine; valid is a one-cycle pulse
// Notes: data shows the inverted level between samples, never a stale copy
`timescale 1ns/1ps
`default_nettype none
module front_end_model
	import math_engine_pkg::*;
#(
	parameter int GAP = 4
)(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [3:0][31:0] level,
	input wire logic [3:0] ovr_in,
	output var sample_s [3:0] samp
);
	int cnt;
	// Sample pulse generator
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 0;
			samp <= '0;
		end else begin
			cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
			for (int i = 0; i < 4; i++) begin
				samp[i].valid <= (cnt == 0);
				samp[i].ovr <= ovr_in[i];
				samp[i].data <= (cnt == 0) ? level[i] : ~level[i];
			end
		end
	end
endmodule
`default_nettype wire

// ---- channel_result_math_engine_bench.sv ----
// Purpose: self-checking bench of the channel result engine over APB
// Assumes: short tick of 1000 cycles, front-end model as sample source
// Notes: expected values worked out from channel levels and operators
`timescale 1ns/1ps
`default_nettype none
module channel_result_math_engine_bench;
	import math_engine_pkg::*;
	logic clk, nrst, ce, psel, penable, pwrite, pslverr, pready, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0][31:0] level;
	logic [3:0] ovr_in;
	sample_s [3:0] samp;
	link_cfg_s cfg232, cfg485;
	int bad_count, num_checks;
	logic [31:0] ftab [3][2];
	// Two full periods plus one worst-case round over all four channels
	localparam int SETTLE = 2700;
	// Tick long enough that channel 0 cannot starve the higher channels
	channel_result_math_engine #(.TICK_CYCLES(1000)) DUT (.clk(clk), .nrst(nrst), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .samp(samp), .cfg232(cfg232),
		.cfg485(cfg485));
	front_end_model fe (.clk(clk), .nrst(nrst), .level(level), .ovr_in(ovr_in), .samp(samp));
	// Clock at 40 MHz
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Channel register address
	function automatic logic [11:0] ca(input int n, input logic [5:0] off);
		return {6'(n + 1), off};
	endfunction
	// One APB transfer, waits for pready under a bound
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		if (n >= 50) begin
			bad_count++;
			$display("mismatch at %0t: no bus answer", $time);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		#(25 * 50000);
		bad_count++;
		report_and_stop();
	end
	// Test sequence
	initial begin
		bad_count = 0;
		num_checks = 0;
		nrst = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		level = {32'h5, 32'h7, 32'h5, 32'h64};
		ovr_in = 4'h0;
		ftab = '{'{32'h0000_8321, 32'd135}, '{32'h0000_f321, 32'd2}, '{32'h0001_6bca, 32'd24}};
		waitc(16);
		nrst <= 1'b1;
		@(posedge clk);
		chk({19'h0, cfg232}, {19'h0, CFG232});
		wr(A_LINK, 32'h0000_1507);
		chk({19'h0, cfg485}, {19'h0, 3'h5, 2'h1, 8'h07});
		chk({19'h0, cfg232}, {19'h0, CFG232});
		rdchk(A_LINK, 32'h0000_1507);
		xfer(1'b0, 12'h3f0, 32'h0);
		chk({31'h0, err}, 32'h1);
		xfer(1'b1, 12'h002, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("test link and bus done");
		wr(ca(2, O_PER), 32'd6000);
		rdchk(ca(2, O_PER), 32'd6000);
		rdchk(A_STAT, 32'h0);
		for (int i = 0; i < 4; i++) wr(ca(i, O_PER), 32'd1);
		wr(A_CTRL, 32'h0000_000d);
		waitc(SETTLE);
		rdchk(ca(0, O_RES), 32'd100);
		rdchk(ca(1, O_RES), 32'd0);
		wr(A_CTRL, 32'h0000_000f);
		waitc(SETTLE);
		$display("test enables done");
		for (int i = 0; i < 3; i++) begin
			wr(A_FUNC, ftab[i][0]);
			waitc(SETTLE);
			rdchk(A_FRES, ftab[i][1]);
		end
		rdchk(ca(2, O_RES), 32'd7);
		$display("test function done");
		wr(A_CTRL, 32'h0000_000d);
		rdchk(ca(1, O_RES), 32'd0);
		ovr_in <= 4'h4;
		waitc(SETTLE);
		rdchk(ca(2, O_RES), MARK);
		rdchk(ca(2, O_MAX), MARK);
		ovr_in <= 4'h0;
		waitc(SETTLE);
		rdchk(ca(2, O_RES), 32'd7);
		rdchk(ca(2, O_MAX), MARK);
		rdchk(ca(2, O_MIN), MARK);
		wr(A_CTRL, 32'h0000_010d);
		waitc(SETTLE);
		rdchk(ca(2, O_MAX), 32'd7);
		rdchk(ca(2, O_MIN), 32'd7);
		$display("test overrange done");
		wr(ca(0, O_LEAD), 32'd5);
		waitc(SETTLE);
		rdchk(ca(0, O_RES), 32'd95);
		wr(A_CTRL, 32'h0000_002f);
		waitc(SETTLE);
		rdchk(ca(1, O_RES), 32'd0);
		level[1] <= 32'd12;
		wr(ca(1, O_X1), 32'd4);
		wr(ca(1, O_X2), 32'd20);
		wr(ca(1, O_Y2), 32'd1200);
		waitc(SETTLE);
		rdchk(ca(1, O_RES), 32'd600);
		$display("test lead and scaling done");
		report_and_stop();
	end
endmodule
`default_nettype wire
